// file: bench/pin_source.sv
`timescale 1ns/1ps
// Outside source on the event pin; it lets go while the unit drives the pin.
module pin_source
(
  input  wire logic lvl,
  input  wire logic pin_o,
  input  wire logic oe_n,
  output logic      pin_i
);
  // The wire follows the unit when it drives, else the source level.
  assign pin_i = oe_n ? lvl : pin_o;
endmodule

// file: bench/test_timer_capture_compare_unit.sv
`timescale 1ns/1ps
module test_timer_capture_compare_unit
  import ccu_pkg::*;
;
  logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready, lvl;
  logic        awready, wready, bvalid, arready, rvalid, pin_i, pin_o, oe_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_r;
  int          failures, compares, cyc, cyc0;

  // Free-running clock and cycle count for the time base estimate.
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Unit under test and the source on its pin.
  ccu_top uut (.CLK(clk), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EVENT_PIN_I(pin_i), .EVENT_PIN_O(pin_o), .EVENT_PIN_OE_N(oe_n));
  pin_source src (.lvl(lvl), .pin_o(pin_o), .oe_n(oe_n), .pin_i(pin_i));

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tmo;
    failures++;
    $display("[ERR] wait expected answer seen none");
    report_and_stop();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    compares++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // Write cycle: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 40);
    if (n >= 40)
      tmo();
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  // Read cycle: the answer is taken at the edge that shows it valid.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 40);
    if (n >= 40)
      tmo();
    d = rdata;
    resp_r = rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  task automatic flag(input logic e);
    logic [31:0] d;
    rd(OFF_FLAGS, d);
    chk("flag", 32'(e) << FLAG_BIT, d & (32'h1 << FLAG_BIT));
  endtask

  // New mode, then the flag is cleared since a mode change may set it.
  task automatic setm(input logic [3:0] m);
    wr(OFF_CTRL, 32'(m), RESP_OKAY);
    wr(OFF_FLAGS, 32'h0, RESP_OKAY);
  endtask

  task automatic pin(input logic v);
    lvl <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic rises(input int n);
    repeat (n)
    begin
      pin(1'b1);
      pin(1'b0);
    end
  endtask

  task automatic t_reset;
    chk("oe_n", 32'h1, 32'(oe_n));
    rdc(OFF_CTRL, 32'(CTRL_RST), "ctrl");
    rdc(OFF_VALUE, 32'(VALUE_RST), "value");
    rdc(OFF_FLAGS, 32'h0, "flags");
    rdc(OFF_ENABLES, 32'(ENABLES_RST), "enables");
    rdc(OFF_DIR, 32'(DIR_RST), "dir");
    chk("rresp", 32'(RESP_OKAY), 32'(resp_r));
    wr(OFF_ENABLES, 32'hff, RESP_OKAY);
    rdc(OFF_ENABLES, 32'(ENABLES_MASK), "enables");
    wr(8'h40, 32'h1, RESP_SLVERR);
    rdc(8'h40, 32'h0, "unmapped");
    chk("rresp", 32'(RESP_SLVERR), 32'(resp_r));
    $display("test reset done");
  endtask

  task automatic t_capture;
    int t;
    logic [31:0] d;
    wr(OFF_DIR, 32'hff, RESP_OKAY);
    setm(CAP_RISE);
    t = cyc - cyc0;
    pin(1'b1);
    flag(1'b1);
    rd(OFF_VALUE, d);
    chk_rng("value", t, t + 8, d);
    flag(1'b1);
    wr(OFF_FLAGS, 32'h0, RESP_OKAY);
    pin(1'b0);
    flag(1'b0);
    setm(CAP_FALL);
    pin(1'b1);
    flag(1'b0);
    t = cyc - cyc0;
    pin(1'b0);
    flag(1'b1);
    rd(OFF_VALUE, d);
    chk_rng("value", t, t + 8, d);
    setm(CAP_RISE);
    rises(1);
    t = cyc - cyc0;
    pin(1'b1);
    rd(OFF_VALUE, d);
    chk_rng("value", t, t + 8, d);
    pin(1'b0);
    $display("test capture done");
  endtask

  task automatic t_prescale;
    setm(CAP_RISE4);
    rises(3);
    flag(1'b0);
    rises(1);
    flag(1'b1);
    setm(CAP_RISE16);
    rises(15);
    flag(1'b0);
    rises(1);
    flag(1'b1);
    setm(CAP_RISE16);
    rises(5);
    setm(CAP_RISE4);
    rises(1);
    flag(1'b1);
    rises(2);
    setm(MODE_OFF);
    setm(CAP_RISE4);
    rises(3);
    flag(1'b0);
    rises(1);
    flag(1'b1);
    rises(2);
    setm(4'h1);
    setm(CAP_RISE4);
    rises(3);
    flag(1'b0);
    // A reset in mid-run must also drop the three counted edges.
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc(OFF_CTRL, 32'(CTRL_RST), "ctrl");
    wr(OFF_CTRL, 32'(CAP_RISE4), RESP_OKAY);
    rises(1);
    flag(1'b0);
    $display("test prescale done");
  endtask

  task automatic t_port;
    wr(OFF_PORT, 32'h0, RESP_OKAY);
    wr(OFF_DIR, 32'hf7, RESP_OKAY);
    setm(CAP_RISE);
    chk("oe_n", 32'h0, 32'(oe_n));
    wr(OFF_PORT, 32'h08, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("pin_o", 32'h1, 32'(pin_o));
    flag(1'b1);
    $display("test port done");
  endtask

  task automatic t_compare;
    logic [3:0]  ms [4] = '{CMP_SET, CMP_FLAG, CMP_CLR, CMP_SPECIAL};
    logic        ep [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic        p;
    logic [31:0] d;
    int          n;
    p = 1'b0;
    setm(MODE_OFF);
    for (int i = 0; i < 4; i++)
    begin
      rd(OFF_TIMER, d);
      wr(OFF_VALUE, d + 32'd60, RESP_OKAY);
      setm(ms[i]);
      flag(1'b0);
      chk("pin_o", 32'(p), 32'(pin_o));
      n = 0;
      do
      begin
        rd(OFF_FLAGS, d);
        n++;
      end
      while (d[FLAG_BIT] !== 1'b1 && n < 100);
      if (n >= 100)
        tmo();
      repeat (2) @(posedge clk);
      if (i < 3)
        chk("pin_o", 32'(ep[i]), 32'(pin_o));
      else
      begin
        rd(OFF_TIMER, d);
        chk_rng("timer", 0, 30, d);
      end
      p = ep[i];
    end
    $display("test compare done");
  endtask

  // Reset, then each scenario in turn.
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {awvalid, wvalid, arvalid, lvl} = 4'h0;
    {bready, rready} = 2'b11;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    failures = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    cyc0 = cyc;
    @(posedge clk);
    t_reset();
    t_capture();
    t_prescale();
    t_port();
    t_compare();
    report_and_stop();
  end
endmodule

// file: src/ccu_edge_prescaler.sv
`timescale 1ns/1ps
module ccu_edge_prescaler
  import ccu_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  arst_n,
  ccu_event_if.det   ev
);

  typedef struct packed {
    logic       prev;
    logic [3:0] count;
  } pre_state_t;

  pre_state_t st_r;
  pre_state_t st_nxt;
  logic       rise;
  logic       fall;
  logic       cap_mode;
  logic       evt;

  // Edge detection and the divided rising-edge counter.
  always_comb
  begin
    st_nxt = st_r;
    evt = 1'b0;
    rise = ev.level & ~st_r.prev;
    fall = ~ev.level & st_r.prev;
    cap_mode = (ev.mode[3:2] == GRP_CAPTURE);
    // Edge history is kept across mode changes, so a change can fire at once.
    st_nxt.prev = ev.level;
    if (!cap_mode)
    begin
      st_nxt.count = 4'h0;
    end
    else
    begin
      // Switching between divided modes leaves the count as it stands.
      case (ev.mode)
        CAP_FALL:   evt = fall;
        CAP_RISE:   evt = rise;
        CAP_RISE4:
        begin
          if (rise && st_r.count >= DIV4_LAST)
          begin
            evt = 1'b1;
            st_nxt.count = 4'h0;
          end
          else if (rise)
          begin
            st_nxt.count = st_r.count + 4'h1;
          end
        end
        CAP_RISE16:
        begin
          if (rise && st_r.count >= DIV16_LAST)
          begin
            evt = 1'b1;
            st_nxt.count = 4'h0;
          end
          else if (rise)
          begin
            st_nxt.count = st_r.count + 4'h1;
          end
        end
        default:    evt = 1'b0;
      endcase
    end
  end

  // State register; any reset clears the prescaler.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ev.evt = evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rise_only:  assert property ((ev.mode == CAP_RISE && evt) |-> ev.level && !$past(ev.level))
    else $error("rising capture without rising edge");
  a_fall_only:  assert property ((ev.mode == CAP_FALL && evt) |-> !ev.level && $past(ev.level))
    else $error("falling capture without falling edge");
  a_div16_full: assert property ((ev.mode == CAP_RISE16 && evt) |-> st_r.count == 4'hf)
    else $error("divide by sixteen fired early");
  a_off_clears: assert property (!cap_mode |=> st_r.count == 4'h0)
    else $error("prescaler not cleared outside capture");
  c_div16_evt:  cover property (ev.mode == CAP_RISE16 && evt);

endmodule

// file: src/ccu_event_if.sv
`timescale 1ns/1ps
// Carries the pin level and mode to the edge prescaler and the capture event back.
interface ccu_event_if;
  logic       level;
  logic [3:0] mode;
  logic       evt;
  modport src (output level, output mode, input evt);
  modport det (input level, input mode, output evt);
endinterface

// file: src/ccu_pkg.sv
package ccu_pkg;

  // Byte addresses of the registers on the AXI4-Lite port.
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_VALUE   = 8'h04;
  localparam logic [7:0] OFF_TIMER   = 8'h08;
  localparam logic [7:0] OFF_FLAGS   = 8'h0c;
  localparam logic [7:0] OFF_DIR     = 8'h10;
  localparam logic [7:0] OFF_PORT    = 8'h14;
  localparam logic [7:0] OFF_ENABLES = 8'h8c;

  // Field positions.
  localparam int FLAG_BIT = 2;
  localparam int PIN_BIT  = 3;

  // Implemented bits of the enable register; bit 3 reads as zero.
  localparam logic [7:0] ENABLES_MASK = 8'hf7;

  // Values after reset.
  localparam logic [5:0]  CTRL_RST    = 6'h00;
  localparam logic [15:0] VALUE_RST   = 16'h0000;
  localparam logic [15:0] TIMER_RST   = 16'h0000;
  localparam logic [7:0]  ENABLES_RST = 8'h00;
  localparam logic [7:0]  DIR_RST     = 8'hff;
  localparam logic [7:0]  PORT_RST    = 8'h00;

  // Mode field encodings.
  localparam logic [3:0] MODE_OFF    = 4'h0;
  localparam logic [3:0] CAP_FALL    = 4'h4;
  localparam logic [3:0] CAP_RISE    = 4'h5;
  localparam logic [3:0] CAP_RISE4   = 4'h6;
  localparam logic [3:0] CAP_RISE16  = 4'h7;
  localparam logic [3:0] CMP_SET     = 4'h8;
  localparam logic [3:0] CMP_CLR     = 4'h9;
  localparam logic [3:0] CMP_FLAG    = 4'ha;
  localparam logic [3:0] CMP_SPECIAL = 4'hb;
  localparam logic [1:0] GRP_CAPTURE = 2'b01;
  localparam logic [1:0] GRP_COMPARE = 2'b10;

  // Last prescaler count before a divided capture fires.
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [0:0] {
    W_IDLE = 1'b0,
    W_RESP = 1'b1
  } wr_state_t;

  typedef enum logic [0:0] {
    R_IDLE = 1'b0,
    R_DATA = 1'b1
  } rd_state_t;

endpackage

// file: src/ccu_top.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - Capture copies timer count into value register.
// - Capture on fall, rise, fourth or sixteenth rise.
// - Capture sets flag bit two; software clears.
// - New capture overwrites unread captured value.
// - Port write on output pin can capture.
// - Mode change may raise a spurious flag.
// - Prescaler cleared when off, non-capture, reset.
// - Prescale change keeps counter; partial first count.
// - Compare value checked against timer every cycle in compare modes.
// - Match sets, clears or keeps pin; sets flag.
// - Mode decode: off and four capture modes.
// - Mode decode: set, clear, flag, special event.
module ccu_top
  import ccu_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        EVENT_PIN_I,
  output logic             EVENT_PIN_O,
  output logic             EVENT_PIN_OE_N
);

  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_out;
    logic        cmp_out;
    logic        flag;
    logic [5:0]  ctrl;
    logic [15:0] value;
    logic [15:0] timer;
    logic [7:0]  enables;
    logic [7:0]  dir;
    logic [7:0]  port;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wr_state_t   wst;
    logic [1:0]  bresp;
    rd_state_t   rst;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } top_state_t;

  top_state_t  st_r;
  top_state_t  st_nxt;
  logic [3:0]  mode;
  logic        cmp_mode;
  logic        match;
  logic        capture_evt;
  logic        wr_fire;
  logic        wr_timer;
  logic        wr_flags;
  logic [7:0]  port_rd;

  ccu_event_if ev ();

  ccu_edge_prescaler u_prescaler (
    .clk    (CLK),
    .arst_n (ARST_N),
    .ev     (ev)
  );

  // Mode decode and the compare of value against the running timer.
  assign mode     = st_r.ctrl[3:0];
  assign cmp_mode = (mode[3:2] == GRP_COMPARE);
  assign match    = cmp_mode && (st_r.timer == st_r.value);
  // The capture input follows the pin as input, or our own drive as output.
  assign ev.level    = st_r.dir[PIN_BIT] ? st_r.pin_s2 : st_r.pin_out;
  assign ev.mode     = mode;
  assign capture_evt = ev.evt;
  assign wr_fire     = st_r.aw_have && st_r.w_have && (st_r.wst == W_IDLE);
  assign wr_timer    = wr_fire && (st_r.aw_addr == OFF_TIMER) && (st_r.w_strb[1:0] != 2'b00);
  assign wr_flags    = wr_fire && (st_r.aw_addr == OFF_FLAGS) && st_r.w_strb[0];
  assign port_rd     = {st_r.port[7:4], ev.level, st_r.port[2:0]};

  // Next state of the unit and of the bus slave.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pin_s1 = EVENT_PIN_I;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.timer = st_r.timer + 16'h0001;
    // Write address and data are taken in either order and held.
    if (AWVALID && AWREADY)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = WDATA;
      st_nxt.w_strb = WSTRB;
    end
    if (wr_fire)
    begin
      st_nxt.wst = W_RESP;
      st_nxt.bresp = RESP_OKAY;
      case (st_r.aw_addr)
        OFF_CTRL:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.ctrl = st_r.w_data[5:0];
          end
        end
        OFF_VALUE:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.value[7:0] = st_r.w_data[7:0];
          end
          if (st_r.w_strb[1])
          begin
            st_nxt.value[15:8] = st_r.w_data[15:8];
          end
        end
        OFF_TIMER:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.timer[7:0] = st_r.w_data[7:0];
          end
          if (st_r.w_strb[1])
          begin
            st_nxt.timer[15:8] = st_r.w_data[15:8];
          end
        end
        OFF_FLAGS:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.flag = st_r.w_data[FLAG_BIT];
          end
        end
        OFF_DIR:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.dir = st_r.w_data[7:0];
          end
        end
        OFF_PORT:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.port = st_r.w_data[7:0];
          end
        end
        OFF_ENABLES:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.enables = st_r.w_data[7:0] & ENABLES_MASK;
          end
        end
        default:     st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.wst == W_RESP && BREADY)
    begin
      st_nxt.wst = W_IDLE;
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
    end
    // Reads answer one cycle after the address is taken.
    if (ARVALID && ARREADY)
    begin
      st_nxt.rst = R_DATA;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      case (ARADDR)
        OFF_CTRL:    st_nxt.rdata[5:0] = st_r.ctrl;
        OFF_VALUE:   st_nxt.rdata[15:0] = st_r.value;
        OFF_TIMER:   st_nxt.rdata[15:0] = st_r.timer;
        OFF_FLAGS:   st_nxt.rdata[FLAG_BIT] = st_r.flag;
        OFF_DIR:     st_nxt.rdata[7:0] = st_r.dir;
        OFF_PORT:    st_nxt.rdata[7:0] = port_rd;
        OFF_ENABLES: st_nxt.rdata[7:0] = st_r.enables;
        default:     st_nxt.rresp = RESP_SLVERR;
      endcase
    end
    if (st_r.rst == R_DATA && RREADY)
    begin
      st_nxt.rst = R_IDLE;
    end
    // A special event restarts the timer unless software writes it.
    if (match && mode == CMP_SPECIAL && !wr_timer)
    begin
      st_nxt.timer = 16'h0000;
    end
    // Capture takes the timer and wins over a software write to the value.
    if (capture_evt)
    begin
      st_nxt.value = st_r.timer;
    end
    // Hardware only ever sets the flag, and a set wins over a clear.
    if (capture_evt || match)
    begin
      st_nxt.flag = 1'b1;
    end
    // Pin action on a match; an unit switched off drops its compare output.
    if (mode == MODE_OFF)
    begin
      st_nxt.cmp_out = 1'b0;
    end
    else if (match && mode == CMP_SET)
    begin
      st_nxt.cmp_out = 1'b1;
    end
    else if (match && mode == CMP_CLR)
    begin
      st_nxt.cmp_out = 1'b0;
    end
    st_nxt.pin_out = (mode[3:2] == GRP_COMPARE) ? st_nxt.cmp_out : st_nxt.port[PIN_BIT];
  end

  // All state of the unit outside the edge prescaler, and the bus slave.
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_r         <= '0;
      st_r.ctrl    <= CTRL_RST;
      st_r.value   <= VALUE_RST;
      st_r.timer   <= TIMER_RST;
      st_r.enables <= ENABLES_RST;
      st_r.dir     <= DIR_RST;
      st_r.port    <= PORT_RST;
      st_r.wst     <= W_IDLE;
      st_r.rst     <= R_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Bus handshakes and registered outputs.
  assign AWREADY        = !st_r.aw_have && (st_r.wst == W_IDLE);
  assign WREADY         = !st_r.w_have && (st_r.wst == W_IDLE);
  assign BVALID         = (st_r.wst == W_RESP);
  assign BRESP          = st_r.bresp;
  assign ARREADY        = (st_r.rst == R_IDLE);
  assign RVALID         = (st_r.rst == R_DATA);
  assign RDATA          = st_r.rdata;
  assign RRESP          = st_r.rresp;
  assign EVENT_PIN_O    = st_r.pin_out;
  assign EVENT_PIN_OE_N = st_r.dir[PIN_BIT];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_capture_copy:  assert property (capture_evt |=> st_r.value == $past(st_r.timer))
    else $error("capture did not copy the timer");
  a_flag_on_event: assert property ((capture_evt || match) |=> st_r.flag)
    else $error("event did not set the flag");
  a_flag_sticky:   assert property ((st_r.flag && !wr_flags) |=> st_r.flag)
    else $error("flag dropped without software clear");
  a_overwrite_val: assert property ((capture_evt && st_r.flag) |=> st_r.value == $past(st_r.timer))
    else $error("second capture did not overwrite");
  a_port_trigger:  assert property ((mode == CAP_RISE && !st_r.dir[PIN_BIT] && $past(mode) == CAP_RISE
                                     && $past(!st_r.dir[PIN_BIT]) && $rose(st_r.pin_out))
                                    |-> capture_evt)
    else $error("port write edge did not capture");
  a_match_set:     assert property ((match && mode == CMP_SET) |=> st_r.cmp_out ##1 st_r.pin_out)
    else $error("set on match failed");
  a_match_clear:   assert property ((match && mode == CMP_CLR) |=> !st_r.cmp_out)
    else $error("clear on match failed");
  a_flag_only:     assert property ((match && mode == CMP_FLAG) |=> $stable(st_r.cmp_out))
    else $error("flag-only mode moved the pin");
  a_special_reset: assert property ((match && mode == CMP_SPECIAL && !wr_timer)
                                    |=> st_r.timer == 16'h0000 ##1 st_r.timer == 16'h0001)
    else $error("special event did not restart timer");
  a_off_output:    assert property (mode == MODE_OFF |=> !st_r.cmp_out)
    else $error("compare output kept while off");

  c_capture:       cover property (capture_evt ##[1:20] capture_evt);
  c_compare_set:   cover property (match && mode == CMP_SET);
  c_special:       cover property (match && mode == CMP_SPECIAL);
  c_port_capture:  cover property (capture_evt && !st_r.dir[PIN_BIT]);

endmodule
